// ---- hw/rse_pkg.sv ----
// constants and types for the regulator and load switch enable registers
package rse_pkg;

    // ******************************************************************
    // register indices (byte address is four times the index)
    // ******************************************************************
    localparam logic [6:0] RSE_IDX_AON_ENABLE = 7'h55;
    localparam logic [6:0] RSE_IDX_AON_CONFIG = 7'h56;
    localparam logic [6:0] RSE_IDX_AON_VOLTAGE = 7'h57;
    localparam logic [6:0] RSE_IDX_AON_PIN_SELECT = 7'h58;
    localparam logic [6:0] RSE_IDX_SW1_ENABLE = 7'h59;
    localparam logic [6:0] RSE_IDX_SW1_CONFIG = 7'h5a;
    localparam logic [6:0] RSE_IDX_SW1_PIN_SELECT = 7'h5b;

    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int RSE_AON_SUPPLY_BIT = 3;
    localparam int RSE_ACT_DSC_BIT = 2;
    localparam int RSE_MODE_BIT = 1;
    localparam int RSE_LOW_Q_BIT = 1;
    localparam int RSE_PSV_DSC_BIT = 0;
    localparam int RSE_SLOT_LSB = 5;
    localparam int RSE_VCODE_W = 5;
    localparam int RSE_PIN_N = 8;

    // ******************************************************************
    // values after reset
    // ******************************************************************
    localparam logic [3:0] RSE_AON_CONFIG_RST = 4'h0;
    localparam logic [4:0] RSE_AON_VOLTAGE_RST = 5'h00;
    localparam logic [7:0] RSE_PIN_SELECT_RST = 8'h00;
    localparam logic [2:0] RSE_SW1_CONFIG_RST = 3'h0;

    // ******************************************************************
    // enumerations
    // ******************************************************************
    typedef enum logic [1:0] {
        RSE_EN_OFF = 2'b00,
        RSE_EN_ON = 2'b01,
        RSE_EN_PINS = 2'b10,
        RSE_EN_RSVD = 2'b11
    } rse_en_field_t;

    typedef enum logic [2:0] {
        RSE_SLOT_OFF = 3'b000,
        RSE_SLOT_ALWAYS = 3'b001,
        RSE_SLOT_AT0 = 3'b010,
        RSE_SLOT_AT25 = 3'b011,
        RSE_SLOT_AT50 = 3'b100,
        RSE_SLOT_CTRL = 3'b111
    } rse_slot_t;

    // boot progress as reported by the sequencer
    localparam logic [2:0] RSE_STAGE_AT0 = 3'h1;
    localparam logic [2:0] RSE_STAGE_AT25 = 3'h2;
    localparam logic [2:0] RSE_STAGE_AT50 = 3'h3;
    localparam logic [2:0] RSE_STAGE_DONE = 3'h4;

    localparam int RSE_SYNC_W = 19;

endpackage : rse_pkg

// ---- hw/rse_regs.sv ----
// enable and configuration registers for the aon regulator and switch one
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps

module rse_regs
    import rse_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // avalon-mm slave
    input wire logic [8:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // pins and device state
    input wire logic [7:0] multipurpose_pin_in,
    input wire logic hard_reset_mode_in,
    input wire logic off_mode_in,
    input wire logic [2:0] boot_stage_in,
    input wire logic [2:0] aon_boot_slot_code_in,
    input wire logic [2:0] switch_one_boot_slot_code_in,
    // aon regulator power stage
    output logic aon_enable_out,
    output logic aon_input_source_sel_out,
    output logic aon_switch_mode_sel_out,
    output logic aon_active_discharge_out,
    output logic aon_passive_discharge_out,
    output logic [4:0] aon_voltage_code_out,
    // load switch one power stage
    output logic switch_one_enable_out,
    output logic switch_one_low_quiescent_out,
    output logic switch_one_active_discharge_out,
    output logic switch_one_passive_discharge_out
);

    // ******************************************************************
    // input synchronisers
    // ******************************************************************
    logic [RSE_SYNC_W-1:0] ext_in;
    logic [RSE_SYNC_W-1:0] meta_r;
    logic [RSE_SYNC_W-1:0] sync_r;

    assign ext_in = {switch_one_boot_slot_code_in, aon_boot_slot_code_in,
                     boot_stage_in, off_mode_in, hard_reset_mode_in,
                     multipurpose_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < RSE_SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk_in or posedge reset_in)
            begin
                if (reset_in)
                begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end
                else
                begin
                    meta_r[gi] <= ext_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    // straps and stage are static or slow; per-bit sync is acceptable
    logic [7:0] pin_s;
    logic hard_s;
    logic off_s;
    logic [2:0] stage_s;
    rse_slot_t aon_slot;
    rse_slot_t sw1_slot;

    assign pin_s = sync_r[7:0];
    assign hard_s = sync_r[8];
    assign off_s = sync_r[9];
    assign stage_s = sync_r[12:10];
    assign aon_slot = rse_slot_t'(sync_r[15:13]);
    assign sw1_slot = rse_slot_t'(sync_r[18:16]);

    // ******************************************************************
    // avalon-mm handshake
    // ******************************************************************
    // one wait cycle per request, then one accept cycle
    logic wait_r;
    logic req;
    logic accept_wr;
    logic [6:0] idx;

    assign req = avs_read_in | avs_write_in;
    assign idx = avs_address_in[8:2];
    assign accept_wr = avs_write_in & ~wait_r & avs_byteenable_in[0];

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            wait_r <= 1'b1;
        else
            wait_r <= ~(req & wait_r);
    end

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [3:0] aon_cfg_r;
    logic [4:0] aon_vcode_r;
    logic [7:0] aon_pinsel_r;
    rse_en_field_t aon_field_r;
    rse_en_field_t sw1_field_r;
    logic [2:0] sw1_cfg_r;
    logic [7:0] sw1_pinsel_r;

    // only implemented bits are stored, so unused bits never act
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            aon_cfg_r <= RSE_AON_CONFIG_RST;
            aon_vcode_r <= RSE_AON_VOLTAGE_RST;
            aon_pinsel_r <= RSE_PIN_SELECT_RST;
            aon_field_r <= RSE_EN_OFF;
            sw1_field_r <= RSE_EN_OFF;
            sw1_cfg_r <= RSE_SW1_CONFIG_RST;
            sw1_pinsel_r <= RSE_PIN_SELECT_RST;
        end
        else if (accept_wr)
        begin
            case (idx)
                RSE_IDX_AON_ENABLE:
                    aon_field_r <= rse_en_field_t'(avs_writedata_in[1:0]);
                RSE_IDX_AON_CONFIG:
                    aon_cfg_r <= avs_writedata_in[3:0];
                RSE_IDX_AON_VOLTAGE:
                    aon_vcode_r <= avs_writedata_in[4:0];
                RSE_IDX_AON_PIN_SELECT:
                    aon_pinsel_r <= avs_writedata_in[7:0];
                RSE_IDX_SW1_ENABLE:
                    sw1_field_r <= rse_en_field_t'(avs_writedata_in[1:0]);
                RSE_IDX_SW1_CONFIG:
                    sw1_cfg_r <= avs_writedata_in[2:0];
                RSE_IDX_SW1_PIN_SELECT:
                    sw1_pinsel_r <= avs_writedata_in[7:0];
                default:
                    aon_cfg_r <= aon_cfg_r;
            endcase
        end
    end

    // ******************************************************************
    // read path
    // ******************************************************************
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        case (idx)
            RSE_IDX_AON_ENABLE:
                rd_byte = {aon_slot, 3'h0, aon_field_r};
            RSE_IDX_AON_CONFIG:
                rd_byte = {4'h0, aon_cfg_r};
            RSE_IDX_AON_VOLTAGE:
                rd_byte = {3'h0, aon_vcode_r};
            RSE_IDX_AON_PIN_SELECT:
                rd_byte = aon_pinsel_r;
            RSE_IDX_SW1_ENABLE:
                rd_byte = {sw1_slot, 3'h0, sw1_field_r};
            RSE_IDX_SW1_CONFIG:
                rd_byte = {5'h00, sw1_cfg_r};
            RSE_IDX_SW1_PIN_SELECT:
                rd_byte = sw1_pinsel_r;
            default:
                rd_byte = 8'h00;
        endcase
    end

    // read data is caught in the wait cycle and stands through accept
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (avs_read_in & wait_r)
            avs_readdata_out <= {24'h00_0000, rd_byte};
    end

    assign avs_waitrequest_out = wait_r;

    // ******************************************************************
    // enable decode
    // ******************************************************************
    function automatic logic en_calc(
        input rse_slot_t slot,
        input rse_en_field_t field,
        input logic [7:0] sel,
        input logic [7:0] pins,
        input logic [2:0] stage,
        input logic always_ok
    );
        logic res;
        res = 1'b0;
        case (slot)
            RSE_SLOT_ALWAYS:
                res = always_ok;
            RSE_SLOT_AT0:
                res = (stage >= RSE_STAGE_AT0);
            RSE_SLOT_AT25:
                res = (stage >= RSE_STAGE_AT25);
            RSE_SLOT_AT50:
                res = (stage >= RSE_STAGE_AT50);
            RSE_SLOT_CTRL:
                if (stage >= RSE_STAGE_DONE)
                begin
                    case (field)
                        RSE_EN_ON:
                            res = 1'b1;
                        RSE_EN_PINS:
                            res = |(sel & pins);
                        default:
                            res = 1'b0;
                    endcase
                end
            default:
                res = 1'b0;
        endcase
        return res;
    endfunction : en_calc

    logic aon_en_nxt;
    logic sw1_en_nxt;

    always_comb
    begin
        aon_en_nxt = en_calc(aon_slot, aon_field_r, aon_pinsel_r,
                             pin_s, stage_s, 1'b1);
        // the switch has no always-on slot; that code is reserved
        sw1_en_nxt = en_calc(sw1_slot, sw1_field_r, sw1_pinsel_r,
                             pin_s, stage_s, 1'b0);
    end

    // ******************************************************************
    // power stage controls
    // ******************************************************************
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            aon_enable_out <= 1'b0;
            switch_one_enable_out <= 1'b0;
        end
        else
        begin
            aon_enable_out <= aon_en_nxt;
            switch_one_enable_out <= sw1_en_nxt;
        end
    end

    // mode is sampled only while the regulator is off
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            aon_switch_mode_sel_out <= 1'b0;
        else if (!aon_enable_out & !aon_en_nxt)
            aon_switch_mode_sel_out <= aon_cfg_r[RSE_MODE_BIT];
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            aon_input_source_sel_out <= 1'b0;
            aon_voltage_code_out <= RSE_AON_VOLTAGE_RST;
            switch_one_low_quiescent_out <= 1'b0;
        end
        else
        begin
            aon_input_source_sel_out <= aon_cfg_r[RSE_AON_SUPPLY_BIT];
            aon_voltage_code_out <= aon_vcode_r;
            switch_one_low_quiescent_out <= sw1_cfg_r[RSE_LOW_Q_BIT];
        end
    end

    // hard reset always discharges; enable bits extend it to off time
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            aon_active_discharge_out <= 1'b0;
            aon_passive_discharge_out <= 1'b0;
            switch_one_active_discharge_out <= 1'b0;
            switch_one_passive_discharge_out <= 1'b0;
        end
        else
        begin
            aon_active_discharge_out <= hard_s
                | (aon_cfg_r[RSE_ACT_DSC_BIT] & ~aon_en_nxt);
            aon_passive_discharge_out <= hard_s
                | (aon_cfg_r[RSE_PSV_DSC_BIT] & ~aon_en_nxt);
            switch_one_active_discharge_out <= hard_s
                | (sw1_cfg_r[RSE_ACT_DSC_BIT] & ~sw1_en_nxt);
            switch_one_passive_discharge_out <= hard_s | off_s
                | (sw1_cfg_r[RSE_PSV_DSC_BIT] & ~sw1_en_nxt);
        end
    end

    // ******************************************************************
    // assertions
    // ******************************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    AST_WAIT_ONE: assert property (req && wait_r |=> !avs_waitrequest_out)
        else $error("request not answered after one wait cycle");

    AST_WAIT_BACK: assert property (!wait_r |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");

    AST_VCODE: assert property (
        accept_wr && idx == RSE_IDX_AON_VOLTAGE
        |=> ##1 aon_voltage_code_out == $past(avs_writedata_in[4:0], 2))
        else $error("voltage code does not follow write");

    AST_MODE_HOLD: assert property (
        aon_enable_out |=> $stable(aon_switch_mode_sel_out))
        else $error("mode changed while regulator enabled");

    AST_AON_PINS: assert property (
        aon_slot == RSE_SLOT_CTRL && stage_s >= RSE_STAGE_DONE
        && aon_field_r == RSE_EN_PINS
        |=> aon_enable_out == $past(|(pin_s & aon_pinsel_r)))
        else $error("regulator enable is not OR of selected pins");

    AST_SW1_PINS: assert property (
        sw1_slot == RSE_SLOT_CTRL && stage_s >= RSE_STAGE_DONE
        && sw1_field_r == RSE_EN_PINS
        |=> switch_one_enable_out == $past(|(pin_s & sw1_pinsel_r)))
        else $error("switch enable is not OR of selected pins");

    AST_SW1_RSVD: assert property (
        (sw1_field_r == RSE_EN_RSVD && sw1_slot == RSE_SLOT_CTRL)
        || (sw1_slot != RSE_SLOT_CTRL && sw1_slot != RSE_SLOT_AT0
        && sw1_slot != RSE_SLOT_AT25 && sw1_slot != RSE_SLOT_AT50)
        |=> !switch_one_enable_out)
        else $error("switch enabled under reserved setting");

    AST_AON_ACT: assert property (
        aon_cfg_r[RSE_ACT_DSC_BIT] && !aon_en_nxt
        |=> aon_active_discharge_out && !aon_enable_out)
        else $error("regulator active discharge missing");

    AST_SW1_PSV: assert property (
        !hard_s && !off_s && !sw1_cfg_r[RSE_PSV_DSC_BIT]
        |=> !switch_one_passive_discharge_out)
        else $error("switch passive discharge without cause");

    AST_RD_ZERO: assert property (
        avs_read_in && !wait_r && idx == RSE_IDX_AON_CONFIG
        |-> avs_readdata_out[31:4] == 28'h000_0000)
        else $error("unused config bits read nonzero");

    COV_WRITE: cover property (accept_wr);
    COV_READ: cover property (avs_read_in && !wait_r);
    COV_PIN_ON: cover property (aon_field_r == RSE_EN_PINS
        && aon_enable_out);
    COV_MODE: cover property (!$stable(aon_switch_mode_sel_out));

endmodule : rse_regs

// ---- testbench/rse_power_stage_model.sv ----
// behavioural regulator and load switch power stages
`timescale 1ns/1ps

module rse_power_stage_model
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // control from the register bank
    input wire logic aon_enable_in,
    input wire logic aon_discharge_in,
    input wire logic [4:0] aon_voltage_code_in,
    input wire logic switch_one_enable_in,
    input wire logic switch_one_discharge_in,
    // rail state
    output int aon_mv_out,
    output logic switch_one_up_out
);
    // a disabled rail with no discharge path keeps its charge
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            aon_mv_out <= 0;
        else if (aon_enable_in)
            aon_mv_out <= 900 + 100 * int'(aon_voltage_code_in);
        else if (aon_discharge_in)
            aon_mv_out <= 0;
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            switch_one_up_out <= 1'b0;
        else if (switch_one_enable_in)
            switch_one_up_out <= 1'b1;
        else if (switch_one_discharge_in)
            switch_one_up_out <= 1'b0;
    end
endmodule : rse_power_stage_model

// ---- testbench/tb_regulator_switch_enable_regs.sv ----
// self-checking bench for the regulator and switch enable registers
`timescale 1ns/1ps

module tb_regulator_switch_enable_regs
    import rse_pkg::*;
;
    // ******************************************************************
    // signals and model state
    // ******************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] adr = 9'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h0;
    logic [7:0] pins = 8'h00;
    logic hard = 1'b0;
    logic off = 1'b0;
    logic [2:0] stage = 3'h4;
    logic [2:0] slot_a = 3'h7;
    logic [2:0] slot_s = 3'h7;
    logic [31:0] rdat;
    logic wreq, en_a, src_a, mode_a, act_a, psv_a;
    logic en_s, lowq_s, act_s, psv_s, up_s;
    logic [4:0] vcode;
    int mv_a;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] mask [7] = '{8'h03, 8'h0f, 8'h1f, 8'hff, 8'h03, 8'h07, 8'hff};
    logic [7:0] m [7] = '{default: 8'h00};
    logic mode_lat = 1'b0;
    int m_mv = 0;
    logic m_up = 1'b0;

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    rse_regs dut (.ref_clk_in(clk), .reset_in(rst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .multipurpose_pin_in(pins),
        .hard_reset_mode_in(hard), .off_mode_in(off),
        .boot_stage_in(stage), .aon_boot_slot_code_in(slot_a),
        .switch_one_boot_slot_code_in(slot_s), .aon_enable_out(en_a),
        .aon_input_source_sel_out(src_a), .aon_switch_mode_sel_out(mode_a),
        .aon_active_discharge_out(act_a), .aon_passive_discharge_out(psv_a),
        .aon_voltage_code_out(vcode), .switch_one_enable_out(en_s),
        .switch_one_low_quiescent_out(lowq_s),
        .switch_one_active_discharge_out(act_s),
        .switch_one_passive_discharge_out(psv_s));

    rse_power_stage_model stage_model (.ref_clk_in(clk), .reset_in(rst),
        .aon_enable_in(en_a), .aon_discharge_in(act_a | psv_a),
        .aon_voltage_code_in(vcode), .switch_one_enable_in(en_s),
        .switch_one_discharge_in(act_s | psv_s), .aon_mv_out(mv_a),
        .switch_one_up_out(up_s));

    // ******************************************************************
    // reference model and helpers
    // ******************************************************************
    function automatic logic en_exp(logic [2:0] s, logic [1:0] f,
        logic [7:0] sel, logic is_reg);
        case (s)
            3'h7: return stage >= 3'h4 && (f == 2'b01
                || (f == 2'b10 && |(sel & pins)));
            3'h1: return is_reg;
            3'h2: return stage >= 3'h1;
            3'h3: return stage >= 3'h2;
            3'h4: return stage >= 3'h3;
            default: return 1'b0;
        endcase
    endfunction : en_exp

    function automatic logic [7:0] reg_exp(logic [7:0] idx);
        int k;
        k = int'(idx) - int'(8'h55);
        if (k < 0 || k > 6) return 8'h00;
        if (k == 0) return {slot_a, 3'b000, m[0][1:0]};
        if (k == 4) return {slot_s, 3'b000, m[4][1:0]};
        return m[k];
    endfunction : reg_exp

    // regulator mode may only follow the config bit while it is off;
    // rails react to every state between writes, so this runs after each
    task automatic track();
        logic ea, es;
        ea = en_exp(slot_a, m[0][1:0], m[3], 1'b1);
        es = en_exp(slot_s, m[4][1:0], m[6], 1'b0);
        if (!ea) mode_lat = m[1][1];
        if (ea) m_mv = 900 + 100 * int'(m[2][4:0]);
        else if (hard | m[1][2] | m[1][0]) m_mv = 0;
        if (es) m_up = 1'b1;
        else if (hard | off | m[5][2] | m[5][0]) m_up = 1'b0;
    endtask : track

    task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic bus(logic w, logic [7:0] idx, logic [7:0] d,
        logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= {idx[6:0], 2'b00};
        wd <= {24'ha5c35a, d};
        be <= b;
        rd <= !w;
        wr <= w;
        do
        begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        if (n >= 50) cmp("waitrequest", 32'h0, 32'(wreq));
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wr_reg(logic [7:0] idx, logic [7:0] d, logic [3:0] b);
        logic [31:0] q;
        int k;
        bus(1'b1, idx, d, b, q);
        k = int'(idx) - int'(8'h55);
        if (b[0] && k >= 0 && k <= 6) m[k] = d & mask[k];
        track();
    endtask : wr_reg

    task automatic rd_chk(logic [7:0] idx);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'hf, q);
        cmp("readback", 32'(reg_exp(idx)), q);
    endtask : rd_chk

    task automatic settle();
        logic ea, es;
        logic [9:0] xa;
        logic [9:0] ga;
        logic [3:0] xs;
        logic [3:0] gs;
        repeat (5) @(posedge clk);
        track();
        ea = en_exp(slot_a, m[0][1:0], m[3], 1'b1);
        es = en_exp(slot_s, m[4][1:0], m[6], 1'b0);
        xa = {ea, m[1][3], mode_lat, hard | (m[1][2] & !ea),
            hard | (m[1][0] & !ea), m[2][4:0]};
        ga = {en_a, src_a, mode_a, act_a, psv_a, vcode};
        xs = {es, m[5][1], hard | (m[5][2] & !es),
            hard | off | (m[5][0] & !es)};
        gs = {en_s, lowq_s, act_s, psv_s};
        cmp("aon enable", 32'(xa[9]), 32'(ga[9]));
        cmp("aon controls", 32'(xa[8:0]), 32'(ga[8:0]));
        cmp("switch enable", 32'(xs[3]), 32'(gs[3]));
        cmp("switch controls", 32'(xs[2:0]), 32'(gs[2:0]));
        cmp("rail state", 32'(m_mv), 32'(mv_a));
        cmp("switch rail", 32'(m_up), 32'(up_s));
    endtask : settle

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // ******************************************************************
    // test sequence
    // ******************************************************************
    initial
    begin
        int i, f, s, g;
        void'($urandom(32'hb91ffcbe));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        settle();
        for (i = 0; i < 7; i++) rd_chk(8'(8'h55 + i));
        rd_chk(8'h54);
        rd_chk(8'h60);
        repeat (4)
        begin
            for (i = 0; i < 7; i++) wr_reg(8'(8'h55 + i), 8'($urandom), 4'h1);
            wr_reg(8'h56, 8'($urandom), 4'he);
            wr_reg(8'h60, 8'hff, 4'hf);
            for (i = 0; i < 7; i++) rd_chk(8'(8'h55 + i));
            settle();
        end
        // every field pair against random pin levels
        for (f = 0; f < 16; f++)
        begin
            wr_reg(8'h55, 8'(f & 3), 4'h1);
            wr_reg(8'h59, 8'(f >> 2), 4'h1);
            repeat (3)
            begin
                pins <= 8'($urandom);
                settle();
            end
        end
        wr_reg(8'h55, 8'h01, 4'h1);
        wr_reg(8'h59, 8'h01, 4'h1);
        for (s = 0; s < 8; s++)
        begin
            for (g = 0; g < 5; g++)
            begin
                slot_a <= 3'(s);
                slot_s <= 3'(s);
                stage <= 3'(g);
                settle();
                rd_chk(8'h59);
            end
        end
        // mode bit written while running must wait for the off state
        wr_reg(8'h56, 8'h02, 4'h1);
        settle();
        wr_reg(8'h55, 8'h00, 4'h1);
        settle();
        wr_reg(8'h56, 8'h05, 4'h1);
        wr_reg(8'h55, 8'h01, 4'h1);
        settle();
        for (i = 0; i < 4; i++)
        begin
            hard <= i[0];
            off <= i[1];
            settle();
        end
        final_report();
    end

    initial
    begin
        #300000;
        n_errors++;
        final_report();
    end
endmodule : tb_regulator_switch_enable_regs
